// [logic/ctd_pkg.sv]
// constants for the control track code detector
package ctd_pkg;
	// ---------------------------------------------
	// register indices, byte address is index * 4
	// ---------------------------------------------
	localparam logic [15:0] IDX_SYNC_STATUS = 16'hFFEF;
	localparam logic [15:0] IDX_INDEX_COUNT = 16'hFFF0;
	localparam logic [15:0] IDX_CLOCK_SEL = 16'hFFF1;
	localparam logic [15:0] IDX_FLAG_CLEAR = 16'hFFF2;
	localparam logic [15:0] IDX_ADDR_DATA = 16'hFFF3;
	// ---------------------------------------------
	// field positions
	// ---------------------------------------------
	localparam int BIT_DUTY = 0;
	localparam int BIT_INDEX = 1;
	localparam int BIT_ADDR = 2;
	localparam int BIT_CLR_INDEX = 0;
	localparam int BIT_CLR_ADDR = 1;
	// ---------------------------------------------
	// reset values and widths
	// ---------------------------------------------
	localparam logic [3:0] RST_INDEX_COUNT = 4'h0;
	localparam logic [1:0] RST_CLOCK_SEL = 2'h0;
	localparam int PERIOD_W = 10;
	localparam int RUN_W = 6;
	localparam int CODE_W = 16;
	localparam logic [5:0] HEADER_RUN = 6'h09;
	localparam logic [3:0] CODE_LAST = 4'hF;
	// shift of time base tap 2 against the clock
	localparam int TAP2_SHIFT = 3;
	// code discriminator states, gray from hunt to shift, two bits flip back to hunt
	typedef enum logic [1:0] {
		CTD_HUNT = 2'b00,
		CTD_WAIT_ZERO = 2'b01,
		CTD_SHIFT = 2'b11
	} ctd_state_t;
endpackage : ctd_pkg

// [logic/ctd_link_if.sv]
// interface between divider, duty and code stages
`timescale 1ns/1ps
`default_nettype none
interface ctd_link_if;
	logic tick; // counter clock enable pulse
	logic res_valid; // duty result pulse
	logic res_bit; // duty result value
	modport div (output tick);
	modport duty (input tick, output res_valid, output res_bit);
	modport code (input res_valid, input res_bit);
endinterface : ctd_link_if
`default_nettype wire

// [logic/ctd_tap_div.sv]
// time base tap divider for the period counter
`timescale 1ns/1ps
`default_nettype none
module ctd_tap_div #(
	parameter int TAP_SHIFT = ctd_pkg::TAP2_SHIFT
) (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic [1:0] i_sel,
	ctd_link_if.div lnk
);
	logic [15:0] cnt_ff; // free running prescaler
	logic [15:0] mask; // low bits for the tap
	logic tick_ff; // registered tap pulse
	// 00 tap 2, 01 tap 4, 10 tap 6, 11 tap 8
	// tap select
	assign mask = 16'((32'h1 << (TAP_SHIFT + 2 * int'(i_sel))) - 1);
	// prescaler count
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cnt_ff <= 16'h0000;
		end else begin
			cnt_ff <= cnt_ff + 16'h0001;
		end
	end
	// one pulse per tap period
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tick_ff <= 1'b0;
		end else begin
			tick_ff <= ((cnt_ff & mask) == mask);
		end
	end
	assign lnk.tick = tick_ff;
	tap_rate_a: assert property (@(posedge i_clock) disable iff (i_rst)
		tick_ff |-> (($past(cnt_ff) & $past(mask)) == $past(mask)))
		else $error("tap pulse off its period");
endmodule : ctd_tap_div
`default_nettype wire

// [logic/ctd_duty.sv]
// duty discriminator: period counter, half latch, sr flop
`timescale 1ns/1ps
`default_nettype none
module ctd_duty (
	input wire logic i_clock,
	input wire logic i_rst,
	input wire logic i_pulse,
	ctd_link_if.duty lnk
);
	localparam int W = ctd_pkg::PERIOD_W;
	logic pulse_ff; // previous pulse level
	logic [W-1:0] cnt_ff; // period up counter
	logic [W-2:0] half_ff; // half of last period
	logic sr_ff; // set-reset hold flop
	logic res_ff; // sampled result
	logic vld_ff; // result pulse
	logic rise, fall, match;
	assign rise = i_pulse & ~pulse_ff;
	assign fall = ~i_pulse & pulse_ff;
	assign match = (cnt_ff[W-2:0] == half_ff);
	// edge detect
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			pulse_ff <= 1'b0;
		end else begin
			pulse_ff <= i_pulse;
		end
	end
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			cnt_ff <= '0;
			half_ff <= '0;
		end else if (rise) begin
			half_ff <= cnt_ff[W-1:1];
			cnt_ff <= '0;
		end else if (lnk.tick && cnt_ff != '1) begin
			cnt_ff <= cnt_ff + W'(1);
		end
	end
	// set at rise, reset on match while high
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			sr_ff <= 1'b1;
		end else if (rise) begin
			sr_ff <= 1'b1;
		end else if (i_pulse && match) begin
			sr_ff <= 1'b0;
		end
	end
	// sample at fall, short high gives 1
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			res_ff <= 1'b0;
			vld_ff <= 1'b0;
		end else begin
			vld_ff <= fall;
			if (fall) begin
				res_ff <= sr_ff;
			end
		end
	end
	assign lnk.res_valid = vld_ff;
	assign lnk.res_bit = res_ff;
	half_latch_a: assert property (@(posedge i_clock) disable iff (i_rst)
		$past(rise) |-> (half_ff == $past(cnt_ff[W-1:1]) && cnt_ff == '0))
		else $error("half period not latched");
	sr_match_a: assert property (@(posedge i_clock) disable iff (i_rst)
		(i_pulse && pulse_ff && match) |=> !sr_ff)
		else $error("match did not reset flop");
	sample_fall_a: assert property (@(posedge i_clock) disable iff (i_rst)
		fall |=> (vld_ff && res_ff == $past(sr_ff)))
		else $error("result not sampled at fall");
endmodule : ctd_duty
`default_nettype wire

// [logic/ctd_detector.sv]
// control track code detector top with AHB-Lite slave
`timescale 1ns/1ps
`default_nettype none
module ctd_detector (
	input wire logic I_CLOCK,
	input wire logic I_RST,
	input wire logic I_HSEL,
	input wire logic [31:0] I_HADDR,
	input wire logic [1:0] I_HTRANS,
	input wire logic I_HWRITE,
	input wire logic [2:0] I_HSIZE,
	input wire logic [31:0] I_HWDATA,
	input wire logic I_HREADY,
	output logic [31:0] O_HRDATA,
	output logic O_HREADYOUT,
	output logic O_HRESP,
	input wire logic I_CTL_PULSE,
	output logic O_CODE_IRQ,
	output logic O_EDGE_IRQ
);
	// ---------------------------------------------
	// internal link and stages
	// ---------------------------------------------
	ctd_link_if lnk ();
	logic [1:0] clk_sel_ff; // counter tap select
	ctd_tap_div u_div (
		.i_clock(I_CLOCK),
		.i_rst(I_RST),
		.i_sel(clk_sel_ff),
		.lnk(lnk)
	);
	// only the shaped track pulse drives it
	ctd_duty u_duty (
		.i_clock(I_CLOCK),
		.i_rst(I_RST),
		.i_pulse(I_CTL_PULSE),
		.lnk(lnk)
	);

	// ---------------------------------------------
	// bus decode
	// ---------------------------------------------
	logic [3:0] idx_set_ff; // index count setting
	logic duty_flag_ff; // last duty result
	logic idx_flag_ff; // index detected
	logic adr_flag_ff; // address word detected
	logic [15:0] adr_data_ff; // latched address word
	logic hi_sel_ff; // next read gives high byte
	logic wr_ff; // write in data phase
	logic [15:0] wr_idx_ff; // index of that write
	logic [31:0] rdata_ff; // read data register
	logic access; // accepted address phase
	logic rd_acc; // accepted read
	logic [15:0] a_idx; // register index of address
	logic a_map; // address inside window
	logic wr_data; // write arriving now
	logic [7:0] wb; // written byte

	// index check for one register
	function automatic logic hit(input logic [15:0] idx,
		input logic [15:0] reg_idx, input logic mapped);
		hit = mapped && (idx == reg_idx);
	endfunction : hit

	assign access = I_HSEL && I_HTRANS[1] && I_HREADY;
	assign rd_acc = access && !I_HWRITE;
	assign a_idx = I_HADDR[17:2];
	assign a_map = (I_HADDR[31:18] == 14'h0000) && (I_HADDR[1:0] == 2'h0);
	assign wr_data = wr_ff;
	assign wb = I_HWDATA[7:0];
	// zero wait states, always okay
	assign O_HREADYOUT = 1'b1;
	assign O_HRESP = 1'b0;

	// capture the write address phase
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			wr_ff <= 1'b0;
			wr_idx_ff <= 16'h0000;
		end else begin
			// unmapped writes are dropped
			wr_ff <= access && I_HWRITE && a_map;
			if (access) begin
				wr_idx_ff <= a_idx;
			end
		end
	end

	// ---------------------------------------------
	// control registers
	// ---------------------------------------------
	// software settings
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			idx_set_ff <= ctd_pkg::RST_INDEX_COUNT;
			clk_sel_ff <= ctd_pkg::RST_CLOCK_SEL;
		end else if (wr_data) begin
			// index count in bits 3 to 0
			if (wr_idx_ff == ctd_pkg::IDX_INDEX_COUNT) begin
				idx_set_ff <= wb[3:0];
			end
			if (wr_idx_ff == ctd_pkg::IDX_CLOCK_SEL) begin
				clk_sel_ff <= wb[1:0];
			end
		end
	end

	// ---------------------------------------------
	// code discriminator
	// ---------------------------------------------
	ctd_pkg::ctd_state_t state_ff; // header/word state
	ctd_pkg::ctd_state_t nxt_state;
	logic [5:0] run_ff; // consecutive ones
	logic [5:0] nxt_run;
	logic zero_seen_ff; // a 0 opened the run
	logic [15:0] shift_ff; // incoming code bits
	logic [3:0] bit_cnt_ff; // bits shifted so far
	logic idx_hit; // index run reached
	logic hdr_hit; // header run reached
	logic adr_done; // sixteenth bit in
	logic vld, bitv;
	assign vld = lnk.res_valid;
	assign bitv = lnk.res_bit;

	always_comb begin
		nxt_run = run_ff;
		if (vld) begin
			if (!bitv) begin
				nxt_run = 6'h00;
			end else if (run_ff != 6'h3F) begin
				nxt_run = run_ff + 6'h01;
			end
		end
	end
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			run_ff <= 6'h00;
			zero_seen_ff <= 1'b0;
		end else begin
			run_ff <= nxt_run;
			if (vld && !bitv) begin
				zero_seen_ff <= 1'b1;
			end
		end
	end

	// run upper bits against setting, once
	assign idx_hit = vld && bitv && (idx_set_ff != 4'h0) &&
		(nxt_run == {idx_set_ff, 2'b00}) && (run_ff != nxt_run);
	assign hdr_hit = vld && bitv && zero_seen_ff &&
		(nxt_run == ctd_pkg::HEADER_RUN) && (run_ff != nxt_run);
	assign adr_done = vld && (state_ff == ctd_pkg::CTD_SHIFT) &&
		(bit_cnt_ff == ctd_pkg::CODE_LAST);

	// header, zero, word sequence
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ctd_pkg::CTD_HUNT: begin
				if (hdr_hit) begin
					nxt_state = ctd_pkg::CTD_WAIT_ZERO;
				end
			end
			ctd_pkg::CTD_WAIT_ZERO: begin
				// the word starts after the next 0
				if (vld && !bitv) begin
					nxt_state = ctd_pkg::CTD_SHIFT;
				end
			end
			ctd_pkg::CTD_SHIFT: begin
				if (adr_done) begin
					nxt_state = ctd_pkg::CTD_HUNT;
				end
			end
			default: begin
				nxt_state = ctd_pkg::CTD_HUNT;
			end
		endcase
	end
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			state_ff <= ctd_pkg::CTD_HUNT;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// shift register, first bit ends in bit 0
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			shift_ff <= 16'h0000;
			bit_cnt_ff <= 4'h0;
		end else if (state_ff != ctd_pkg::CTD_SHIFT) begin
			bit_cnt_ff <= 4'h0;
		end else if (vld) begin
			shift_ff <= {bitv, shift_ff[15:1]};
			bit_cnt_ff <= bit_cnt_ff + 4'h1;
		end
	end
	// word latch keeps reads stable
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			adr_data_ff <= 16'h0000;
		end else if (adr_done) begin
			adr_data_ff <= {bitv, shift_ff[15:1]};
		end
	end

	// ---------------------------------------------
	// flags and interrupts
	// ---------------------------------------------
	logic clr_idx, clr_adr;
	assign clr_idx = wr_data && (wr_idx_ff == ctd_pkg::IDX_FLAG_CLEAR) &&
		wb[ctd_pkg::BIT_CLR_INDEX];
	assign clr_adr = wr_data && (wr_idx_ff == ctd_pkg::IDX_FLAG_CLEAR) &&
		wb[ctd_pkg::BIT_CLR_ADDR];
	// detect flags, set wins over clear
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			idx_flag_ff <= 1'b0;
			adr_flag_ff <= 1'b0;
		end else begin
			if (idx_hit) begin
				idx_flag_ff <= 1'b1;
			end else if (clr_idx) begin
				idx_flag_ff <= 1'b0;
			end
			if (adr_done) begin
				adr_flag_ff <= 1'b1;
			end else if (clr_adr) begin
				adr_flag_ff <= 1'b0;
			end
		end
	end
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			duty_flag_ff <= 1'b0;
		end else if (vld) begin
			duty_flag_ff <= bitv;
		end
	end
	// one shared code pulse, edge pulse per result
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			O_CODE_IRQ <= 1'b0;
			O_EDGE_IRQ <= 1'b0;
		end else begin
			O_CODE_IRQ <= idx_hit || adr_done;
			O_EDGE_IRQ <= vld;
		end
	end

	// ---------------------------------------------
	// read path
	// ---------------------------------------------
	// byte pointer of the address word
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			hi_sel_ff <= 1'b0;
		end else if (wr_data && wr_idx_ff == ctd_pkg::IDX_ADDR_DATA) begin
			// write rewinds to the low byte
			hi_sel_ff <= 1'b0;
		end else if (rd_acc && hit(a_idx, ctd_pkg::IDX_ADDR_DATA, a_map)) begin
			hi_sel_ff <= ~hi_sel_ff;
		end
	end
	// read data chosen in address phase
	always_ff @(posedge I_CLOCK) begin
		if (I_RST) begin
			rdata_ff <= 32'h00000000;
		end else if (rd_acc) begin
			rdata_ff <= 32'h00000000;
			if (hit(a_idx, ctd_pkg::IDX_SYNC_STATUS, a_map)) begin
				rdata_ff[ctd_pkg::BIT_DUTY] <= duty_flag_ff;
				rdata_ff[ctd_pkg::BIT_INDEX] <= idx_flag_ff;
				rdata_ff[ctd_pkg::BIT_ADDR] <= adr_flag_ff;
			end
			if (hit(a_idx, ctd_pkg::IDX_INDEX_COUNT, a_map)) begin
				rdata_ff[3:0] <= idx_set_ff;
			end
			if (hit(a_idx, ctd_pkg::IDX_CLOCK_SEL, a_map)) begin
				rdata_ff[1:0] <= clk_sel_ff;
			end
			if (hit(a_idx, ctd_pkg::IDX_ADDR_DATA, a_map)) begin
				rdata_ff[7:0] <= hi_sel_ff ? adr_data_ff[15:8] : adr_data_ff[7:0];
			end
		end
	end
	assign O_HRDATA = rdata_ff;

	// ---------------------------------------------
	// checks
	// ---------------------------------------------
	index_flag_set_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		idx_hit |=> (idx_flag_ff && O_CODE_IRQ))
		else $error("index hit lost");
	index_off_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(idx_set_ff == 4'h0 && !adr_done) |=> !O_CODE_IRQ)
		else $error("index fired while disabled");
	flag_clear_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(clr_adr && !adr_done) |=> !adr_flag_ff)
		else $error("address flag not cleared");
	shared_irq_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		O_CODE_IRQ |-> ($past(idx_flag_ff) || idx_flag_ff || adr_flag_ff))
		else $error("irq without flag");
	header_run_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		hdr_hit |=> (run_ff == ctd_pkg::HEADER_RUN))
		else $error("header at wrong run");
	word_len_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		adr_done |=> (adr_flag_ff && state_ff == ctd_pkg::CTD_HUNT))
		else $error("word end not flagged");
	ptr_rewind_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(wr_data && wr_idx_ff == ctd_pkg::IDX_ADDR_DATA) |=> !hi_sel_ff)
		else $error("pointer not rewound");
	ptr_toggle_a: assert property (@(posedge I_CLOCK) disable iff (I_RST)
		(rd_acc && hit(a_idx, ctd_pkg::IDX_ADDR_DATA, a_map) && !wr_data)
		|=> (hi_sel_ff != $past(hi_sel_ff)))
		else $error("pointer did not toggle");
endmodule : ctd_detector
`default_nettype wire

// [test/ctd_track_src.sv]
// track pulse source standing in for the shaped playback control track
`timescale 1ns/1ps
`default_nettype none
module ctd_track_src (
	input wire logic i_clock,
	input wire logic i_rst,
	output logic o_pulse
);
	// ---------------------------------------------
	// queues and timing
	// ---------------------------------------------
	logic bit_q[$]; // bits to send, zero filler when empty
	logic sent_q[$]; // bits whose falling edge has passed
	int tick_len = 8; // clocks per counter tick
	int per_len; // clocks per period, sixteen ticks
	int hi_len; // high time of this pulse
	logic cur; // bit being sent
	// ---------------------------------------------
	// pulse train, no gaps so every period is measured
	// ---------------------------------------------
	initial begin
		o_pulse = 1'b0;
		forever begin
			@(posedge i_clock);
			if (!i_rst) begin
				cur = (bit_q.size() > 0) ? bit_q.pop_front() : 1'b0;
				per_len = 16 * tick_len;
				hi_len = cur ? per_len * 11 / 40 : per_len * 3 / 5;
				o_pulse <= 1'b1;
				repeat (hi_len) @(posedge i_clock);
				o_pulse <= 1'b0;
				sent_q.push_back(cur);
				repeat (per_len - hi_len - 1) @(posedge i_clock);
			end
		end
	end
endmodule : ctd_track_src
`default_nettype wire

// [test/tb.sv]
// self-checking bench for the control track code detector
`timescale 1ns/1ps
`default_nettype none
module tb;
	// ---------------------------------------------
	// design connections
	// ---------------------------------------------
	logic clock = 1'b0; // 40 MHz
	logic rst = 1'b1; // synchronous reset
	logic hsel = 1'b0; // bus select
	logic [31:0] haddr = 32'h0; // byte address
	logic [1:0] htrans = 2'h0; // transfer type
	logic hwrite = 1'b0; // direction
	logic [31:0] hwdata = 32'h0; // write data
	wire logic [31:0] hrdata; // read data
	wire logic hreadyout; // slave ready
	wire logic hresp; // response
	wire logic pulse; // track pulse
	wire logic code_irq; // code event
	wire logic edge_irq; // duty result event
	// ---------------------------------------------
	// reference model state
	// ---------------------------------------------
	int miscompares = 0;
	int comparisons = 0;
	int results = 0; // duty results seen
	int code_seen = 0; // code pulses seen
	int ref_irqs = 0; // code pulses expected
	int skip = 1; // results with an unreliable reference
	int run = 0; // consecutive ones
	int st = 0; // 0 hunt, 1 wait zero, 2 shift
	int sh_cnt = 0; // bits shifted
	int idx_set = 0; // index count setting
	logic zero_seen = 1'b0, ref_idx = 1'b0, ref_addr = 1'b0, addr_new = 1'b0;
	logic r_valid = 1'b0, r_bit = 1'b0;
	logic [15:0] word = 16'h0; // expected address word
	logic [31:0] got_w[$]; // words read back
	int sets[3] = '{0, 1, 15};

	ctd_detector u_ctd_detector (.I_CLOCK(clock), .I_RST(rst), .I_HSEL(hsel), .I_HADDR(haddr),
		.I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
		.I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
		.I_CTL_PULSE(pulse), .O_CODE_IRQ(code_irq), .O_EDGE_IRQ(edge_irq));
	ctd_track_src u_ctd_track_src (.i_clock(clock), .i_rst(rst), .o_pulse(pulse));

	always #12.5 clock = ~clock;

	// ---------------------------------------------
	// checks and bus cycles
	// ---------------------------------------------
	task chk_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
		end
	endtask : chk_reg
	task chk_count(input int got, input int exp, input string what);
		comparisons++;
		if (got != exp) begin
			miscompares++;
			$display("unexpected at %0t: %s got %0d want %0d", $time, what, got, exp);
		end
	endtask : chk_count
	// one transfer: address phase, then data phase, each held until ready
	task bus(input logic [15:0] idx, input logic w, input logic [7:0] v, output logic [31:0] d);
		@(posedge clock);
		hsel <= 1'b1;
		htrans <= 2'h2;
		haddr <= {14'h0, idx, 2'h0};
		hwrite <= w;
		do begin @(posedge clock); end while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, v};
		do begin @(posedge clock); end while (hreadyout !== 1'b1);
		d = hrdata;
		chk_reg({31'h0, hresp}, 32'h0, "response");
	endtask : bus
	task wr(input logic [15:0] idx, input logic [7:0] v);
		logic [31:0] d;
		bus(idx, 1'b1, v, d);
	endtask : wr
	task rd(input logic [15:0] idx, output logic [31:0] d);
		bus(idx, 1'b0, 8'h00, d);
	endtask : rd
	// ---------------------------------------------
	// reference detector, fed one result at a time
	// ---------------------------------------------
	task feed(input logic b);
		run = b ? ((run < 63) ? run + 1 : 63) : 0;
		if (st == 2) begin
			word[sh_cnt] = b;
			sh_cnt++;
			if (sh_cnt == 16) begin st = 0; ref_addr = 1'b1; addr_new = 1'b1; ref_irqs++; end
		end else if (!b) begin
			zero_seen = 1'b1;
			if (st == 1) begin st = 2; sh_cnt = 0; end
		end else if (st == 0 && zero_seen && run == 9) st = 1;
		if (b && idx_set != 0 && run == 4 * idx_set) begin ref_idx = 1'b1; ref_irqs++; end
	endtask : feed
	always @(posedge clock) begin
		if (edge_irq === 1'b1) begin
			r_bit = u_ctd_track_src.sent_q.pop_front();
			r_valid = (skip == 0);
			if (skip > 0) skip--;
			else feed(r_bit);
			results++;
		end
		if (code_irq === 1'b1) code_seen++;
	end
	task push_bits(input logic [31:0] v, input int n);
		for (int i = 0; i < n; i++) u_ctd_track_src.bit_q.push_back(v[i % 32]);
	endtask : push_bits
	// ---------------------------------------------
	// result tracking and register views
	// ---------------------------------------------
	task read_word;
		logic [31:0] lo, hi, ag;
		rd(ctd_pkg::IDX_ADDR_DATA, lo);
		rd(ctd_pkg::IDX_ADDR_DATA, hi);
		rd(ctd_pkg::IDX_ADDR_DATA, ag);
		chk_reg(lo, {24'h0, word[7:0]}, "word low");
		chk_reg(hi, {24'h0, word[15:8]}, "word high");
		chk_reg(ag, {24'h0, word[7:0]}, "word low again");
		wr(ctd_pkg::IDX_ADDR_DATA, 8'h5A);
		rd(ctd_pkg::IDX_ADDR_DATA, ag);
		chk_reg(ag, {24'h0, word[7:0]}, "low after rewind");
		wr(ctd_pkg::IDX_ADDR_DATA, 8'h00);
		got_w.push_back({16'h0, hi[7:0], lo[7:0]});
	endtask : read_word
	task chk_flags(input logic [31:0] d);
		chk_reg({30'h0, d[ctd_pkg::BIT_ADDR], d[ctd_pkg::BIT_INDEX]},
			{30'h0, ref_addr, ref_idx}, "detect flags");
	endtask : chk_flags
	task track(input int n);
		logic [31:0] d;
		int seen;
		repeat (n) begin
			seen = results;
			while (results == seen) @(posedge clock);
			@(posedge clock);
			rd(ctd_pkg::IDX_SYNC_STATUS, d);
			if (r_valid) chk_reg({31'h0, d[ctd_pkg::BIT_DUTY]}, {31'h0, r_bit}, "duty");
			chk_flags(d);
			if (addr_new) begin addr_new = 1'b0; read_word(); end
		end
		chk_count(code_seen, ref_irqs, "code events");
	endtask : track
	task clr(input logic [7:0] v);
		logic [31:0] d;
		wr(ctd_pkg::IDX_FLAG_CLEAR, v);
		if (v[ctd_pkg::BIT_CLR_INDEX]) ref_idx = 1'b0;
		if (v[ctd_pkg::BIT_CLR_ADDR]) ref_addr = 1'b0;
		rd(ctd_pkg::IDX_SYNC_STATUS, d);
		chk_flags(d);
	endtask : clr
	task tally_and_finish;
		if (miscompares == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : tally_and_finish
	// ---------------------------------------------
	// main sequence and watchdog
	// ---------------------------------------------
	initial begin
		logic [31:0] d, e;
		d = $urandom(40);
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		rd(ctd_pkg::IDX_SYNC_STATUS, d);
		chk_flags(d);
		rd(ctd_pkg::IDX_CLOCK_SEL, d);
		chk_reg(d & 32'h3, 32'h0, "select at reset");
		rd(16'hFFE0, d);
		chk_reg(d, 32'h0, "unmapped read");
		d = $urandom;
		wr(ctd_pkg::IDX_INDEX_COUNT, d[7:0]);
		rd(ctd_pkg::IDX_INDEX_COUNT, e);
		chk_reg(e & 32'hF, {28'h0, d[3:0]}, "index count");
		foreach (sets[i]) begin
			wr(ctd_pkg::IDX_INDEX_COUNT, 8'(sets[i]));
			idx_set = sets[i];
			push_bits(32'hFFFF_FFFF, 4 * idx_set + 3);
			track(4 * idx_set + 23);
		end
		clr(8'h01);
		clr(8'h02);
		wr(ctd_pkg::IDX_INDEX_COUNT, 8'h00);
		idx_set = 0;
		got_w.delete();
		d = $urandom;
		repeat (2) begin push_bits(32'h3FE, 11); push_bits({16'h0, d[15:0]}, 16); end
		track(57);
		chk_count(got_w.size(), 2, "words read");
		chk_reg(got_w[0], {16'h0, d[15:0]}, "address word");
		chk_reg(got_w[1], got_w[0], "repeated word");
		for (int s = 0; s < 4; s++) begin
			wr(ctd_pkg::IDX_CLOCK_SEL, 8'(s));
			rd(ctd_pkg::IDX_CLOCK_SEL, d);
			chk_reg(d & 32'h3, 32'(s), "clock select");
			u_ctd_track_src.tick_len = 8 << (2 * s);
			skip = 2;
			push_bits(32'h2, 3);
			track(4);
		end
		tally_and_finish();
	end
	initial begin
		repeat (98000) @(posedge clock);
		miscompares++;
		$display("unexpected at %0t: watchdog expired", $time);
		tally_and_finish();
	end
endmodule : tb
`default_nettype wire
